// *** intc_pkg.sv ***
// Constants, register map and carrier types of the four-level interrupt controller.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package intc_pkg;

  localparam int NSRC = 13;
  localparam int NPER = 9;

  // Register byte addresses.
  localparam logic [7:0] OFS_IEN_A  = 8'h00;
  localparam logic [7:0] OFS_IEN_B  = 8'h04;
  localparam logic [7:0] OFS_PL_A   = 8'h08;
  localparam logic [7:0] OFS_PH_A   = 8'h0C;
  localparam logic [7:0] OFS_PL_B   = 8'h10;
  localparam logic [7:0] OFS_PH_B   = 8'h14;
  localparam logic [7:0] OFS_PWR    = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_EVT_ST = 8'h20;
  localparam logic [7:0] OFS_EVT_CL = 8'h24;
  localparam logic [7:0] OFS_EVT_EN = 8'h28;
  localparam logic [7:0] OFS_TECR   = 8'h88;

  // Field positions.
  localparam int TECR_TF1   = 7;
  localparam int TECR_TR1   = 6;
  localparam int TECR_TF0   = 5;
  localparam int TECR_TR0   = 4;
  localparam int TECR_FLAG1 = 3;
  localparam int TECR_TRIG1 = 2;
  localparam int TECR_FLAG0 = 1;
  localparam int TECR_TRIG0 = 0;
  localparam int IEN_GLOBAL = 7;
  localparam int PWR_IDLE = 0;
  localparam int PWR_PD   = 1;
  localparam int PWR_XTAL = 2;
  localparam int EVT_WAKE = 0;
  localparam int EVT_VEC  = 1;
  localparam int EVT_NEST = 2;

  // Source numbers; a lower number ranks first among equal levels.
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TMR0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TMR1 = 4'h3;

  // Reset values.
  localparam logic [7:0] TECR_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;

  // Wake-up timing.
  localparam int OSC_CYC_XTAL  = 992;
  localparam int OSC_CYC_OTHER = 224;
  localparam int WAKE_EXTRA_US = 60;
  localparam int CLK_MHZ       = 100;
  localparam int WAKE_EXTRA_CYC = WAKE_EXTRA_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PWR_RUN   = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_DOWN  = 2'b10,
    PWR_WAKE  = 2'b11
  } pwr_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic insn_start;
    logic irq_ack;
    logic irq_ret;
  } cpu_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] id;
    logic [1:0] level;
  } vec_t;

endpackage

// *** ext_int_detect.sv ***
// One external interrupt input with its request flag.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ns
module ext_int_detect
  import intc_pkg::*;
(
  input  wire logic clk,       // Core clock.
  input  wire logic rst_n,     // Synchronous reset, active low.
  input  wire logic pin,       // Sampled external pin.
  input  wire logic trig_edge, // High selects falling-edge mode.
  input  wire logic clr,       // Clears the flag in edge mode.
  output logic      flag       // Request flag.
);

  typedef struct packed {
    logic prev;
    logic flag;
  } det_t;

  det_t s_r;
  det_t s_nxt;

  // Edge mode sets on a high sample then a low one; the set beats a clear.
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = pin;
    if (!trig_edge) begin
      s_nxt.flag = ~pin;
    end else if (s_r.prev && !pin) begin
      s_nxt.flag = 1'b1;
    end else if (clr) begin
      s_nxt.flag = 1'b0;
    end
  end

  // The previous sample resets high, so a pin low on the first sample after reset counts as a fall in edge mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '{prev: 1'b1, flag: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag = s_r.flag;

endmodule

// *** wake_timer.sv ***
// Wake-up delay: source-clock cycles, then a fixed stretch of core cycles.
// Assumes osc_tick pulses once per source-clock cycle.
`timescale 1ns/1ns
module wake_timer
  import intc_pkg::*;
#(
  parameter int EXTRA_CYC = WAKE_EXTRA_CYC
)(
  input  wire logic clk,      // Core clock.
  input  wire logic rst_n,    // Synchronous reset, active low.
  input  wire logic start,    // Starts a delay.
  input  wire logic xtal,     // High for a crystal source.
  input  wire logic osc_tick, // One pulse per source-clock cycle.
  output logic      done      // One-cycle pulse at the end.
);

  typedef struct packed {
    logic [1:0]  phase;
    logic [15:0] cnt;
    logic        done;
  } wt_t;

  wt_t s_r;
  wt_t s_nxt;

  // Phase 1 counts source ticks, phase 2 counts core cycles.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.phase)
      2'd0: if (start) begin
        s_nxt.phase = 2'd1;
        s_nxt.cnt = xtal ? 16'(OSC_CYC_XTAL) : 16'(OSC_CYC_OTHER);
      end
      2'd1: if (osc_tick) begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          s_nxt.phase = 2'd2;
          s_nxt.cnt = 16'(EXTRA_CYC);
        end
      end
      2'd2: begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt == 16'h0001) begin
          s_nxt.phase = 2'd0;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.phase = 2'd0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;

endmodule

// *** intc_top.sv ***
// Four-level interrupt controller with wake-up control and an APB slave.
// Assumes synchronous inputs, one CPU that answers vectors, and one clock.
//
// What this block does
// - Accept thirteen sources: two external, two timers, serial, system and bus peripherals.
// - Four priority levels per source, one bit each from low and high registers.
// - A source with its enable bit clear never gets serviced.
// - Global enable bit in the first enable register masks every source.
// - Active routine is preempted only by a strictly higher level.
// - A routine at the top level is never preempted.
// - Equal-level requests at an instruction start are picked by fixed ranking.
// - Ranking only breaks ties; it never overrides programmed priority.
// - Two external interrupt pins, apart from the keypad source.
// - Each external input is level or falling-edge, by its trigger-type bit.
// - Edge mode sets the flag on a high sample followed by a low.
// - An enabled external interrupt wakes the core from idle or power-down.
// - Crystal wake-up holds the core clock 992 source cycles plus 60 us.
// - Other sources hold the core clock 224 source cycles plus 60 us.
// - Timer/external control register at 88H, resets to zero, fixed bit order.
// - Idle ends on any enabled interrupt request or on reset.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module intc_top
  import intc_pkg::*;
#(
  parameter int EXTRA_CYC = WAKE_EXTRA_CYC
)(
  input  wire logic            clk,          // Core clock, 100 MHz.
  input  wire logic            rst_n,        // Synchronous reset, active low.
  input  apb_req_t             apb,          // APB request.
  output logic                 pready,       // APB ready.
  output logic [31:0]          prdata,       // APB read data.
  output logic                 pslverr,      // APB error, unmapped address.
  input  wire logic [1:0]      ext_int_pin,  // External pins, index 1 and 0.
  input  wire logic [1:0]      tmr_ovf,      // Timer overflow pulses.
  input  wire logic [NPER-1:0] periph_req,   // Other sources, levels, ids 4 to 12.
  input  wire logic            source_clock, // Source-clock tick pulse.
  input  cpu_req_t             cpu,          // CPU handshake.
  output vec_t                 vec,          // Vector offered to the CPU.
  output logic [1:0]           tmr_run,      // Timer run bits.
  output logic                 core_clk_en,  // Core clock gate.
  output logic                 irq           // Status interrupt.
);

  typedef struct packed {
    logic [7:0]  tecr;
    logic [7:0]  ien_a;
    logic [7:0]  ien_b;
    logic [7:0]  pl_a;
    logic [7:0]  ph_a;
    logic [7:0]  pl_b;
    logic [7:0]  ph_b;
    logic        xtal;
    pwr_t        pwr;
    logic [3:0]  in_svc;
    vec_t        vec;
    logic [2:0]  evt_st;
    logic [2:0]  evt_en;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        clk_en;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [1:0]      ext_flag;
  logic [1:0]      ext_clr;
  logic            wake_done;
  logic            wr_en;
  logic            rd_phase;
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] en_all;
  logic [NSRC-1:0] pend;
  logic [1:0]      prio [NSRC];
  logic            found;
  logic [3:0]      best_id;
  logic [1:0]      best_lvl;
  logic [1:0]      act_lvl;
  logic            take;
  logic            ext_wake;
  logic [31:0]     rdata;
  logic            unmapped;

  // Access phase is one wait state; the write lands where pready is sampled.
  assign rd_phase = apb.psel && apb.penable && !s_r.pready;
  assign wr_en    = apb.psel && apb.penable && s_r.pready && apb.pwrite;

  // Software clears an edge flag by writing zero; so does vectoring to it.
  always_comb begin
    ext_clr[0] = cpu.irq_ack && s_r.vec.valid && s_r.vec.id == SRC_EXT0;
    ext_clr[1] = cpu.irq_ack && s_r.vec.valid && s_r.vec.id == SRC_EXT1;
    if (wr_en && apb.paddr == OFS_TECR) begin
      ext_clr[0] = ext_clr[0] || !apb.pwdata[TECR_FLAG0];
      ext_clr[1] = ext_clr[1] || !apb.pwdata[TECR_FLAG1];
    end
  end

  // The two external inputs share one detector design.
  for (genvar g = 0; g < 2; g++) begin : g_ext
    ext_int_detect u_det (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin       (ext_int_pin[g]),
      .trig_edge (s_r.tecr[g == 0 ? TECR_TRIG0 : TECR_TRIG1]),
      .clr       (ext_clr[g]),
      .flag      (ext_flag[g])
    );
  end

  // Power-down wake delay; the source choice picks the first count.
  wake_timer #(
    .EXTRA_CYC (EXTRA_CYC)
  ) u_wake (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (s_r.pwr == PWR_DOWN && ext_wake),
    .xtal     (s_r.xtal),
    .osc_tick (source_clock),
    .done     (wake_done)
  );

  // Thirteen request lines gated by their own and the global enable.
  always_comb begin
    raw = {periph_req, s_r.tecr[TECR_TF1], ext_flag[1], s_r.tecr[TECR_TF0], ext_flag[0]};
    en_all = {s_r.ien_b[5:0], s_r.ien_a[6:0]};
    pend = raw & en_all & {NSRC{s_r.ien_a[IEN_GLOBAL]}};
    for (int i = 0; i < NSRC; i++) begin
      if (i < 7) begin
        prio[i] = {s_r.ph_a[i], s_r.pl_a[i]};
      end else begin
        prio[i] = {s_r.ph_b[i-7], s_r.pl_b[i-7]};
      end
    end
  end

  // A strictly higher level replaces the candidate, so ties keep the lower id.
  always_comb begin
    found = 1'b0;
    best_id = 4'h0;
    best_lvl = 2'd0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && (!found || prio[i] > best_lvl)) begin
        found = 1'b1;
        best_id = 4'(i);
        best_lvl = prio[i];
      end
    end
  end

  // Level of the innermost routine in service.
  always_comb begin
    act_lvl = 2'd0;
    for (int l = 0; l < 4; l++) begin
      if (s_r.in_svc[l]) begin
        act_lvl = 2'(l);
      end
    end
    take = found && (s_r.in_svc == 4'h0 || best_lvl > act_lvl);
    ext_wake = pend[SRC_EXT0] || pend[SRC_EXT1];
  end

  // Register read mux; the external request flags come from the detectors.
  always_comb begin
    rdata = 32'h0000_0000;
    unmapped = 1'b0;
    case (apb.paddr)
      OFS_IEN_A:  rdata[7:0] = s_r.ien_a;
      OFS_IEN_B:  rdata[7:0] = s_r.ien_b;
      OFS_PL_A:   rdata[7:0] = s_r.pl_a;
      OFS_PH_A:   rdata[7:0] = s_r.ph_a;
      OFS_PL_B:   rdata[7:0] = s_r.pl_b;
      OFS_PH_B:   rdata[7:0] = s_r.ph_b;
      OFS_PWR:    rdata[4:0] = {s_r.pwr, s_r.xtal, s_r.pwr == PWR_DOWN, s_r.pwr == PWR_SLEEP};
      OFS_STAT:   rdata[10:0] = {s_r.vec, s_r.in_svc};
      OFS_EVT_ST: rdata[2:0] = s_r.evt_st;
      OFS_EVT_CL: rdata = 32'h0000_0000;
      OFS_EVT_EN: rdata[2:0] = s_r.evt_en;
      OFS_TECR: begin
        rdata[7:0] = s_r.tecr;
        rdata[TECR_FLAG1] = ext_flag[1];
        rdata[TECR_FLAG0] = ext_flag[0];
      end
      default:    unmapped = 1'b1;
    endcase
  end

  // Main next-state logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = rd_phase;
    s_nxt.pslverr = rd_phase && unmapped;
    s_nxt.prdata = rd_phase ? rdata : 32'h0000_0000;
    if (wr_en && !unmapped) begin
      case (apb.paddr)
        OFS_IEN_A:  s_nxt.ien_a = apb.pwdata[7:0];
        OFS_IEN_B:  s_nxt.ien_b = apb.pwdata[7:0];
        OFS_PL_A:   s_nxt.pl_a = apb.pwdata[7:0];
        OFS_PH_A:   s_nxt.ph_a = apb.pwdata[7:0];
        OFS_PL_B:   s_nxt.pl_b = apb.pwdata[7:0];
        OFS_PH_B:   s_nxt.ph_b = apb.pwdata[7:0];
        OFS_PWR: begin
          s_nxt.xtal = apb.pwdata[PWR_XTAL];
          if (s_r.pwr == PWR_RUN && apb.pwdata[PWR_PD]) begin
            s_nxt.pwr = PWR_DOWN;
          end else if (s_r.pwr == PWR_RUN && apb.pwdata[PWR_IDLE]) begin
            s_nxt.pwr = PWR_SLEEP;
          end
        end
        OFS_EVT_CL: s_nxt.evt_st = s_r.evt_st & ~apb.pwdata[2:0];
        OFS_EVT_EN: s_nxt.evt_en = apb.pwdata[2:0];
        OFS_TECR:   s_nxt.tecr = apb.pwdata[7:0] & 8'hF5;
        default:    s_nxt.tecr = s_r.tecr;
      endcase
    end
    // Overflow sets win over a software clear in the same cycle.
    if (tmr_ovf[0]) begin
      s_nxt.tecr[TECR_TF0] = 1'b1;
    end
    if (tmr_ovf[1]) begin
      s_nxt.tecr[TECR_TF1] = 1'b1;
    end
    // Arbitration happens only at instruction starts while the core runs.
    if (cpu.insn_start && s_r.pwr == PWR_RUN) begin
      s_nxt.vec = '{valid: take, id: best_id, level: best_lvl};
      if (take) begin
        s_nxt.evt_st[EVT_VEC] = 1'b1;
        if (s_r.in_svc != 4'h0) begin
          s_nxt.evt_st[EVT_NEST] = 1'b1;
        end
      end
    end
    // Return pops the innermost level; acknowledge then pushes the new one.
    if (cpu.irq_ret) begin
      s_nxt.in_svc[act_lvl] = 1'b0;
    end
    if (cpu.irq_ack && s_r.vec.valid) begin
      s_nxt.in_svc[s_r.vec.level] = 1'b1;
      s_nxt.vec.valid = 1'b0;
      if (s_r.vec.id == SRC_TMR0) begin
        s_nxt.tecr[TECR_TF0] = tmr_ovf[0];
      end
      if (s_r.vec.id == SRC_TMR1) begin
        s_nxt.tecr[TECR_TF1] = tmr_ovf[1];
      end
    end
    // Power state machine.
    case (s_r.pwr)
      PWR_RUN:   s_nxt.pwr = s_nxt.pwr;
      PWR_SLEEP: if (found) begin
        s_nxt.pwr = PWR_RUN;
      end
      PWR_DOWN:  if (ext_wake) begin
        s_nxt.pwr = PWR_WAKE;
      end
      PWR_WAKE:  if (wake_done) begin
        s_nxt.pwr = PWR_RUN;
        s_nxt.evt_st[EVT_WAKE] = 1'b1;
      end
      default:   s_nxt.pwr = PWR_RUN;
    endcase
    // Idle keeps the core clock gated too; the CPU resumes on its return.
    s_nxt.clk_en = s_nxt.pwr == PWR_RUN;
    s_nxt.irq = |(s_nxt.evt_st & s_nxt.evt_en);
  end

  // All control state resets to a defined value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.tecr <= TECR_RST;
      s_r.ien_a <= REG_RST;
      s_r.clk_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready      = s_r.pready;
  assign prdata      = s_r.prdata;
  assign pslverr     = s_r.pslverr;
  assign vec         = s_r.vec;
  assign tmr_run     = {s_r.tecr[TECR_TR1], s_r.tecr[TECR_TR0]};
  assign core_clk_en = s_r.clk_en;
  assign irq         = s_r.irq;

  // Checks on the arbitration and wake paths.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_src_enable: assert property (
    $past(cpu.insn_start && s_r.pwr == PWR_RUN) && vec.valid
      |-> $past(en_all[best_id]) && vec.id == $past(best_id))
    else $error("vector issued for a disabled source");
  chk_global_mask: assert property (
    cpu.insn_start && s_r.pwr == PWR_RUN && !s_r.ien_a[IEN_GLOBAL] |=> !vec.valid)
    else $error("vector issued with global enable clear");
  chk_nest_level: assert property (
    $rose(vec.valid) && $past(act_lvl == 2'd1 && s_r.in_svc[1]) |-> vec.level > 2'd1)
    else $error("preemption at equal or lower level");
  chk_top_level: assert property (
    s_r.in_svc[3] && cpu.insn_start && s_r.pwr == PWR_RUN |=> !vec.valid)
    else $error("top level routine preempted");
  chk_rank_tie: assert property (
    $past(cpu.insn_start && s_r.pwr == PWR_RUN && pend[4]) && vec.valid
      && $past(prio[4]) == vec.level |-> vec.id <= 4'h4)
    else $error("ranking order not kept");
  chk_prio_wins: assert property (
    $past(cpu.insn_start && s_r.pwr == PWR_RUN && pend[9] && prio[9] == 2'd3) && vec.valid
      |-> vec.level == 2'd3)
    else $error("lower level served before higher");
  chk_edge_flag: assert property (
    s_r.tecr[TECR_TRIG0] && $past(ext_int_pin[0]) && !ext_int_pin[0] |=> ext_flag[0])
    else $error("falling edge missed");
  chk_level_flag: assert property (
    !s_r.tecr[TECR_TRIG1] && !ext_int_pin[1] |=> ext_flag[1])
    else $error("level request dropped");
  chk_idle_exit: assert property (s_r.pwr == PWR_SLEEP && found |=> core_clk_en)
    else $error("idle not ended by request");
  chk_pd_hold: assert property ($rose(s_r.pwr == PWR_WAKE) |-> !core_clk_en [*8])
    else $error("core clock restarted too early");

endmodule

// *** cpu_model.sv ***
// Behavioural CPU core that faces the vector port of the interrupt controller.
// Assumes one clock; the bench calls its tasks, one at a time, from one process.
`timescale 1ns/1ns
module cpu_model
  import intc_pkg::*;
(
  input  wire logic clk, // Core clock.
  input  vec_t      vec, // Vector offered by the controller.
  output cpu_req_t  cpu  // Handshake pulses towards the controller.
);
  // Idle at time zero so the controller sees no stray pulse out of reset.
  initial begin
    cpu = '0;
  end

  // One instruction start; the vector is looked at one cycle after it was taken.
  // The acknowledge is only given while the vector is valid, as a real core would.
  task automatic arbitrate(input logic take, output vec_t seen);
    @(posedge clk);
    cpu.insn_start <= 1'b1;
    @(posedge clk);
    cpu.insn_start <= 1'b0;
    @(posedge clk);
    seen = vec;
    if (take && seen.valid === 1'b1) begin
      cpu.irq_ack <= 1'b1;
      @(posedge clk);
      cpu.irq_ack <= 1'b0;
    end
  endtask

  // Return from the innermost service routine.
  task automatic ret();
    @(posedge clk);
    cpu.irq_ret <= 1'b1;
    @(posedge clk);
    cpu.irq_ret <= 1'b0;
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the interrupt controller: registers over APB, arbitration,
// nesting, external pins, timers, wake-up and the status interrupt.
// Assumes the controller answers every APB access within a few cycles.
`timescale 1ns/1ns
module tb
  import intc_pkg::*;
;
  localparam int EXTRA = 20;
  typedef struct packed {
    logic [7:0] ia, ib, la, ha, lb, hb;
    logic [8:0] rq;
    vec_t       ex;
  } row_t;

  logic            clk, rst_n, pready, pslverr, core_clk_en, irq, src_tick, err;
  apb_req_t        apb;
  logic [31:0]     prdata, q;
  logic [1:0]      pin, tmr_ovf, tmr_run;
  logic [NPER-1:0] rq;
  cpu_req_t        cpu;
  vec_t            vec, seen;
  int              bad_count, total_checks, n;
  row_t            rows [6];
  logic [7:0]      rlist [9];

  intc_top #(.EXTRA_CYC(EXTRA)) intc_top_i (.clk(clk), .rst_n(rst_n), .apb(apb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_int_pin(pin),
    .tmr_ovf(tmr_ovf), .periph_req(rq), .source_clock(src_tick), .cpu(cpu),
    .vec(vec), .tmr_run(tmr_run), .core_clk_en(core_clk_en), .irq(irq));
  cpu_model cpu_model_i (.clk(clk), .vec(vec), .cpu(cpu));

  // Clock, and a source-clock tick every second core cycle.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) src_tick <= rst_n ? ~src_tick : 1'b0;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait that never sees pready.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk("register read", {24'h0, e}, q);
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic set_prio(input row_t r);
    xfer(1'b1, OFS_IEN_A, {24'h0, r.ia});
    xfer(1'b1, OFS_IEN_B, {24'h0, r.ib});
    xfer(1'b1, OFS_PL_A, {24'h0, r.la});
    xfer(1'b1, OFS_PH_A, {24'h0, r.ha});
    xfer(1'b1, OFS_PL_B, {24'h0, r.lb});
    xfer(1'b1, OFS_PH_B, {24'h0, r.hb});
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // A hang is cut short well past the longest wake-up delay.
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0; apb = '0; pin = 2'b11; tmr_ovf = 2'b00; rq = '0;
    rows[0] = '{8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 9'h005, '{1'b1, 4'h4, 2'd0}};
    rows[1] = '{8'hFF, 8'h3F, 8'h00, 8'h40, 8'h00, 8'h00, 9'h005, '{1'b1, 4'h6, 2'd2}};
    rows[2] = '{8'h7F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 9'h005, '{1'b0, 4'h0, 2'd0}};
    rows[3] = '{8'hC0, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 9'h005, '{1'b1, 4'h6, 2'd0}};
    rows[4] = '{8'hFF, 8'h3F, 8'h10, 8'h00, 8'h04, 8'h04, 9'h021, '{1'b1, 4'h9, 2'd3}};
    rows[5] = '{8'hFF, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 9'h1F8, '{1'b1, 4'h7, 2'd0}};
    rlist = '{OFS_IEN_A, OFS_IEN_B, OFS_PL_A, OFS_PH_A, OFS_PL_B, OFS_PH_B,
              OFS_PWR, OFS_EVT_ST, OFS_TECR};
    wait_n(12);
    rst_n <= 1'b1;
    chk("core_clk_en", 1, core_clk_en);
    foreach (rlist[i]) rd(rlist[i], 8'h00);
    xfer(1'b0, 8'h40, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped data", 0, q);
    xfer(1'b1, OFS_EVT_EN, 32'h2);
    // Arbitration table: enables, levels and pending requests against the vector.
    foreach (rows[i]) begin
      set_prio(rows[i]);
      @(posedge clk) rq <= rows[i].rq;
      cpu_model_i.arbitrate(1'b0, seen);
      chk("vec valid", rows[i].ex.valid, seen.valid);
      if (rows[i].ex.valid) chk("vec id", rows[i].ex.id, seen.id);
      if (rows[i].ex.valid) chk("vec level", rows[i].ex.level, seen.level);
    end
    wait_n(2);
    chk("irq raised", 1, irq);
    xfer(1'b1, OFS_EVT_CL, 32'h7);
    wait_n(2);
    chk("irq cleared", 0, irq);
    xfer(1'b1, OFS_EVT_EN, 32'h0);
    // Nesting: level 1 in service, then same level, higher level and top level.
    set_prio('{8'hFF, 8'h3F, 8'h50, 8'h00, 8'h0C, 8'h0C, 9'h0, '0});
    @(posedge clk) rq <= 9'h001;
    cpu_model_i.arbitrate(1'b1, seen);
    chk("nest first", 5'b10100, {seen.valid, seen.id});
    @(posedge clk) rq <= 9'h005;
    cpu_model_i.arbitrate(1'b0, seen);
    chk("same level held", 0, seen.valid);
    @(posedge clk) rq <= 9'h025;
    cpu_model_i.arbitrate(1'b1, seen);
    chk("preempt", 7'b1100111, seen);
    @(posedge clk) rq <= 9'h065;
    cpu_model_i.arbitrate(1'b0, seen);
    chk("top level held", 0, seen.valid);
    cpu_model_i.ret();
    cpu_model_i.ret();
    @(posedge clk) rq <= '0;
    // External pin 0: level mode follows the pin, edge mode latches the fall.
    xfer(1'b1, OFS_TECR, 32'h00);
    @(posedge clk) pin[0] <= 1'b0;
    wait_n(3);
    rd(OFS_TECR, 8'h02);
    @(posedge clk) pin[0] <= 1'b1;
    wait_n(3);
    rd(OFS_TECR, 8'h00);
    xfer(1'b1, OFS_TECR, 32'h01);
    @(posedge clk) pin[0] <= 1'b0;
    wait_n(3);
    @(posedge clk) pin[0] <= 1'b1;
    wait_n(3);
    rd(OFS_TECR, 8'h03);
    xfer(1'b1, OFS_TECR, 32'h01);
    rd(OFS_TECR, 8'h01);
    // External pin 1 as a vectored source; the vector is not acknowledged.
    xfer(1'b1, OFS_TECR, 32'h00);
    xfer(1'b1, OFS_IEN_A, 32'h84);
    @(posedge clk) pin[1] <= 1'b0;
    wait_n(2);
    cpu_model_i.arbitrate(1'b0, seen);
    chk("ext1 vector", 5'b10010, {seen.valid, seen.id});
    @(posedge clk) pin[1] <= 1'b1;
    // Timer run and overflow bits share the control register.
    xfer(1'b1, OFS_TECR, 32'h50);
    wait_n(1);
    chk("tmr_run", 2'b11, tmr_run);
    @(posedge clk) tmr_ovf <= 2'b01;
    @(posedge clk) tmr_ovf <= 2'b00;
    wait_n(2);
    rd(OFS_TECR, 8'h70);
    xfer(1'b1, OFS_TECR, 32'h00);
    // Power-down wake-up by external pin 0, crystal and other source.
    xfer(1'b1, OFS_IEN_A, 32'h81);
    for (int x = 0; x < 2; x++) begin
      xfer(1'b1, OFS_PWR, {29'h0, x[0], 2'b10});
      wait_n(3);
      chk("clock gated", 0, core_clk_en);
      @(posedge clk) pin[0] <= 1'b0;
      n = 0;
      @(posedge clk);
      while (core_clk_en !== 1'b1 && n < 5000) begin
        @(posedge clk);
        n++;
      end
      chk("wake delay", 1, n >= 2 * (x ? OSC_CYC_XTAL : OSC_CYC_OTHER) + EXTRA - 4
        && n <= 2 * (x ? OSC_CYC_XTAL : OSC_CYC_OTHER) + EXTRA + 8);
      @(posedge clk) pin[0] <= 1'b1;
      wait_n(3);
    end
    xfer(1'b0, OFS_EVT_ST, 32'h0);
    chk("wake event", 1, q[EVT_WAKE]);
    // Idle ends on an enabled peripheral request.
    xfer(1'b1, OFS_IEN_A, 32'h90);
    xfer(1'b1, OFS_PWR, 32'h1);
    wait_n(3);
    chk("idle gated", 0, core_clk_en);
    @(posedge clk) rq <= 9'h001;
    wait_n(4);
    chk("idle ended", 1, core_clk_en);
    // A reset in mid-run brings the control register back to zero.
    xfer(1'b1, OFS_TECR, 32'h50);
    @(posedge clk) rst_n <= 1'b0;
    wait_n(2);
    @(posedge clk) rst_n <= 1'b1;
    chk("tmr_run reset", 0, tmr_run);
    rd(OFS_TECR, 8'h00);
    tally_and_finish();
  end
endmodule
